// *** hdl/bsfs_sequencer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "bsfs_defs.vh"
module bsfs_sequencer (
  input  wire        mclk,          // 250 MHz
  input  wire        resetn,        // async, active low
  input  wire        uvloActive,    // supply below lockout
  input  wire        startReqN,     // start request, active low
  input  wire        cycleStart,    // oscillator cycle pulse
  input  wire [8:0]  cycleTicks,    // ticks per switching cycle
  input  wire [8:0]  pwmOnTicks,    // on time asked by PWM comparator
  input  wire [1:0]  pinCurrentClass, // sensed pin current class
  input  wire        overTripCmp,   // high-side drop above level
  input  wire        rampAboveFb,   // ramp above feedback
  input  wire        outAboveTarget,// pre-bias above target
  input  wire [10:0] extRefMv,      // external reference, mV
  output reg         oscRun,        // oscillator enable
  output reg         calSenseEn,    // calibration sense connected
  output reg  [8:0]  tripLevelMv,   // latched trip level
  output reg  [10:0] intRefMv,      // internal reference, mV
  output reg         highSideGate,  // main switch drive
  output reg         lowSideGate,   // rectifier drive
  output reg         overcurrentPulse, // one-tick overcurrent flag
  output reg         faultActive,   // fault timeout running
  output reg         regulating     // soft-start done
);
  // ==================================================
  // state
  localparam ST_OFF = 3'd0;
  localparam ST_CAL = 3'd1;
  localparam ST_SS  = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_FLT = 3'd4;

  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [12:0] cnt_ff;
  reg [12:0] nxt_cnt;
  reg [2:0]  periods_ff;
  reg [2:0]  nxt_periods;
  reg [10:0] rampAcc_ff;
  reg [10:0] nxt_rampAcc;
  reg [2:0]  faults_ff;
  reg [2:0]  nxt_faults;
  reg        ocSeen_ff;
  reg [8:0]  phase_ff;
  reg [8:0]  srWidth_ff;
  reg        srFull_ff;
  reg        pwmGo_ff;
  reg        hsCut_ff;

  function [8:0] trip_for;
    input [1:0] cls;
    begin
      case (cls)
        `BSFS_SEL_LOW:  trip_for = `BSFS_TRIP_LOW;
        `BSFS_SEL_HIGH: trip_for = `BSFS_TRIP_HIGH;
        default:        trip_for = `BSFS_TRIP_NONE;
      endcase
    end
  endfunction

  wire switching = (state_ff == ST_SS) || (state_ff == ST_RUN);
  wire ssActive = (state_ff == ST_SS);
  wire blanked = phase_ff < `BSFS_BLANK_TICKS;
  wire hsOnWin = switching && pwmGo_ff && !hsCut_ff
                 && (phase_ff < pwmOnTicks);
  wire ocNow = hsOnWin && !blanked && overTripCmp;
  wire [8:0] srLead = cycleTicks - srWidth_ff;
  wire srWindow = srFull_ff ? (phase_ff >= pwmOnTicks)
                            : (phase_ff >= srLead) && (srWidth_ff != 9'h000);
  wire [10:0] rampSum = rampAcc_ff + `BSFS_RAMP_NUM;

  // ==================================================
  // sequencing on switching-cycle boundaries; seventh-pulse fault entry and start release act at once
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_periods = periods_ff;
    nxt_rampAcc = rampAcc_ff;
    nxt_faults = faults_ff;
    if (cycleStart) begin
      if (switching) begin
        // one step per cycle, floored at zero
        if (ocSeen_ff)
          nxt_faults = faults_ff + 3'd1;
        else if (faults_ff != 3'd0)
          nxt_faults = faults_ff - 3'd1;
      end
      case (state_ff)
        ST_OFF: begin
          if (!startReqN) begin
            nxt_state = ST_CAL;
            nxt_cnt = 13'h0000;
          end
        end
        ST_CAL: begin
          nxt_cnt = cnt_ff + 13'h0001;
          if (cnt_ff[11:0] == `BSFS_CAL_CYC - 12'h001) begin
            nxt_state = ST_SS;
            nxt_rampAcc = 11'h000;
          end
        end
        ST_SS: begin
          // fixed slope: 5/12 mV per cycle = 0.25 V/ms
          if (rampSum >= `BSFS_RAMP_DEN)
            nxt_rampAcc = rampSum - `BSFS_RAMP_DEN;
          else
            nxt_rampAcc = rampSum;
          if (intRefMv >= extRefMv)
            nxt_state = ST_RUN;
        end
        ST_RUN: nxt_state = ST_RUN;
        ST_FLT: begin
          nxt_cnt = cnt_ff + 13'h0001;
          if (cnt_ff == `BSFS_SS_PERIOD_CYC - 13'h0001) begin
            nxt_cnt = 13'h0000;
            nxt_periods = periods_ff + 3'd1;
            if (periods_ff == `BSFS_TIMEOUT_PERIODS - 3'd1) begin
              nxt_state = ST_OFF;
              nxt_faults = 3'd0;
            end
          end
        end
        default: nxt_state = ST_OFF;
      endcase
      if (switching && nxt_faults == `BSFS_FAULT_LIMIT) begin
        nxt_state = ST_FLT;
        nxt_cnt = 13'h0000;
        nxt_periods = 3'd0;
      end
    end
    if (switching && ocSeen_ff && faults_ff == `BSFS_FAULT_LIMIT - 3'd1
        && !cycleStart) begin
      nxt_state = ST_FLT;
      nxt_cnt = 13'h0000;
      nxt_periods = 3'd0;
      nxt_faults = `BSFS_FAULT_LIMIT;
    end
    if (startReqN && state_ff != ST_FLT)
      nxt_state = ST_OFF;
  end

  // ==================================================
  // registers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_OFF;
      cnt_ff <= 13'h0000;
      periods_ff <= 3'd0;
      rampAcc_ff <= 11'h000;
      faults_ff <= 3'd0;
      ocSeen_ff <= 1'b0;
      phase_ff <= 9'h000;
      srWidth_ff <= 9'h000;
      srFull_ff <= 1'b0;
      pwmGo_ff <= 1'b0;
      hsCut_ff <= 1'b0;
      oscRun <= 1'b0;
      calSenseEn <= 1'b0;
      tripLevelMv <= `BSFS_TRIP_NONE;
      intRefMv <= 11'h000;
      highSideGate <= 1'b0;
      lowSideGate <= 1'b0;
      overcurrentPulse <= 1'b0;
      faultActive <= 1'b0;
      regulating <= 1'b0;
    end else if (uvloActive) begin
      state_ff <= ST_OFF;
      faults_ff <= 3'd0;
      ocSeen_ff <= 1'b0;
      oscRun <= 1'b0;
      calSenseEn <= 1'b0;
      highSideGate <= 1'b0;
      lowSideGate <= 1'b0;
      overcurrentPulse <= 1'b0;
      faultActive <= 1'b0;
      regulating <= 1'b0;
      intRefMv <= 11'h000;
      srFull_ff <= 1'b0;
      srWidth_ff <= 9'h000;
      pwmGo_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      periods_ff <= nxt_periods;
      rampAcc_ff <= nxt_rampAcc;
      faults_ff <= nxt_faults;
      oscRun <= 1'b1;
      phase_ff <= cycleStart ? 9'h000 : phase_ff + 9'h001;
      // counted once per cycle on the next boundary; a pulse that makes the count seven counts at once
      if (cycleStart)
        ocSeen_ff <= 1'b0;
      else if (ocNow)
        ocSeen_ff <= 1'b1;
      if (cycleStart)
        hsCut_ff <= 1'b0;
      else if (ocNow)
        hsCut_ff <= 1'b1;
      overcurrentPulse <= ocNow;
      calSenseEn <= (state_ff == ST_CAL);
      if (state_ff == ST_CAL)
        tripLevelMv <= trip_for(pinCurrentClass);
      faultActive <= (state_ff == ST_FLT);
      regulating <= (state_ff == ST_RUN);
      if (state_ff == ST_RUN)
        intRefMv <= extRefMv;
      else if (ssActive && cycleStart && intRefMv < extRefMv
               && rampSum >= `BSFS_RAMP_DEN)
        intRefMv <= intRefMv + 11'h001;
      else if (!switching)
        intRefMv <= 11'h000;
      // pulses held back while output sits above the ramp
      if (!switching)
        pwmGo_ff <= 1'b0;
      else if (rampAboveFb || state_ff == ST_RUN)
        pwmGo_ff <= 1'b1;
      // rectifier soft entry, widened each cycle
      if (!switching) begin
        srWidth_ff <= 9'h000;
        srFull_ff <= 1'b0;
      end else if (state_ff == ST_RUN && outAboveTarget) begin
        srFull_ff <= 1'b1;
      end else if (cycleStart && pwmGo_ff && !srFull_ff) begin
        if (srWidth_ff == 9'h000)
          srWidth_ff <= `BSFS_SR_MIN_TICKS;
        else if (srLead <= pwmOnTicks + `BSFS_SR_STEP_TICKS)
          srFull_ff <= 1'b1;
        else
          srWidth_ff <= srWidth_ff + `BSFS_SR_STEP_TICKS;
      end
      highSideGate <= hsOnWin && !ocNow;
      lowSideGate <= switching && pwmGo_ff && srWindow
                     && !(phase_ff < pwmOnTicks && !srFull_ff);
    end
  end
endmodule
`default_nettype wire

// *** hdl/bsfs_defs.vh ***
// Functional notes
// - stay off until start request pulled low
// - calibrate trip level before any soft-start
// - ramp internal reference up to external reference
// - ramp slope fixed, duration scales with reference
// - current limiting active during soft-start
// - no full rectification early in soft-start
// - pre-bias: pulses start once ramp exceeds feedback
// - diode after high pulse, then short low pulse
// - low pulse widens each cycle to 1-D
// - full rectification then two-quadrant operation
// - output above target: rectifier on at ramp end
// - blank overcurrent compare early in each cycle
// - overcurrent ends high pulse and flags pulse
// - counter up after pulse, down otherwise
// - count seven declares fault, high gate off
// - both gates off during fault timeout
// - timeout is seven soft-start periods, then restart
// - sensed current class selects one of three levels
// - latch level, disconnect sensing, then soft-start
// - undervoltage lockout holds all gates low
// - calibration samples pin current for 1 ms
`ifndef BSFS_DEFS_VH
`define BSFS_DEFS_VH
// switching cycles at 600 kHz
`define BSFS_CYC_PER_MS      10'd600
`define BSFS_CAL_MS          2'd1
`define BSFS_CAL_CYC         12'd600
// reference in 1 mV steps; 0.25 V/ms over 600 cycles/ms
`define BSFS_REF_W           11
`define BSFS_SS_FULL_MV      11'd1500
`define BSFS_RAMP_NUM        11'd5
`define BSFS_RAMP_DEN        11'd12
`define BSFS_FAULT_LIMIT     3'd7
`define BSFS_TIMEOUT_PERIODS 3'd7
`define BSFS_SS_PERIOD_CYC   13'd3600
// trip levels in mV
`define BSFS_TRIP_NONE       9'd180
`define BSFS_TRIP_LOW        9'd105
`define BSFS_TRIP_HIGH       9'd310
`define BSFS_SEL_NONE        2'd0
`define BSFS_SEL_LOW         2'd1
`define BSFS_SEL_HIGH        2'd2
// sub-cycle ticks of mclk within a switching cycle
`define BSFS_PHASE_W         9
`define BSFS_BLANK_TICKS     9'd40
`define BSFS_SR_MIN_TICKS    9'd8
`define BSFS_SR_STEP_TICKS   9'd4
`endif

// *** verification/bsfs_far_side.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsfs_far_side (
  input  wire logic        startOn,        // bench asks for start
  input  wire logic        overload,       // shorted output
  input  wire logic [10:0] fbMv,           // pre-bias level
  input  wire logic [10:0] intRefMv,       // ramp from dut
  input  wire logic [10:0] extRefMv,       // reference
  input  wire logic        highSideGate,   // main drive
  output logic             startReqN,      // pulled up when idle
  output logic             overTripCmp,    // drop above level
  output logic             rampAboveFb,    // ramp over feedback
  output logic             outAboveTarget  // pre-bias too high
);
  assign startReqN = !startOn;
  // drop only shows while the main switch conducts
  assign overTripCmp = overload && highSideGate;
  assign rampAboveFb = intRefMv > fbMv;
  assign outAboveTarget = fbMv > extRefMv;
endmodule
`default_nettype wire

// *** verification/bsfs_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "bsfs_defs.vh"
module bsfs_properties (
  input wire logic        mclk,             // clock
  input wire logic        resetn,           // reset
  input wire logic        uvloActive,       // lockout
  input wire logic        startReqN,        // start
  input wire logic        cycleStart,       // cycle
  input wire logic        rampAboveFb,      // fb compare
  input wire logic [10:0] extRefMv,         // reference
  input wire logic        oscRun,           // oscillator
  input wire logic        calSenseEn,       // sensing
  input wire logic [8:0]  tripLevelMv,      // level
  input wire logic [10:0] intRefMv,         // ramp
  input wire logic        highSideGate,     // main
  input wire logic        lowSideGate,      // rectifier
  input wire logic        overcurrentPulse, // flag
  input wire logic        faultActive,      // fault
  input wire logic        regulating        // run
);
  logic [8:0] tickCnt_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================
  // helpers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) tickCnt_ff <= 9'h000;
    else if (cycleStart) tickCnt_ff <= 9'h000;
    else tickCnt_ff <= tickCnt_ff + 9'h001;
  end
  sequence s_calDone;
    $fell(calSenseEn) && !startReqN && !uvloActive;
  endsequence
  // ==========================
  // properties
  AST_UNDERVOLTAGE_LOCKOUT_OFF:
    assert property (uvloActive |=> !oscRun && !highSideGate && !lowSideGate)
    else $error("drive in lockout");
  AST_SS_START:
    assert property (s_calDone |-> ##[1:300] intRefMv != 11'h000)
    else $error("no ramp after cal");
  AST_RAMP_STEP:
    assert property (!calSenseEn && $changed(intRefMv) && intRefMv != 11'h000
      |-> intRefMv == $past(intRefMv) + 11'h001) else $error("ramp step");
  AST_HOLD_REF:
    assert property (regulating |-> intRefMv == extRefMv)
    else $error("ref not held");
  AST_TRIP_HOLD:
    assert property (regulating && $past(regulating) |-> $stable(tripLevelMv))
    else $error("level moved");
  AST_PREBIAS:
    assert property ($rose(highSideGate) && !regulating |-> rampAboveFb)
    else $error("early pulse");
  AST_BLANK:
    assert property (overcurrentPulse |-> tickCnt_ff >= `BSFS_BLANK_TICKS)
    else $error("blanking");
  AST_OC_CUT:
    assert property (overcurrentPulse |=> !overcurrentPulse && !highSideGate)
    else $error("pulse not ended");
  AST_FAULT_OFF:
    assert property (faultActive |=> !highSideGate && !lowSideGate)
    else $error("gate on in fault");
endmodule
bind bsfs_sequencer bsfs_properties i_props (.mclk(mclk), .resetn(resetn),
  .uvloActive(uvloActive), .startReqN(startReqN), .cycleStart(cycleStart),
  .rampAboveFb(rampAboveFb), .extRefMv(extRefMv), .oscRun(oscRun),
  .calSenseEn(calSenseEn), .tripLevelMv(tripLevelMv), .intRefMv(intRefMv),
  .highSideGate(highSideGate), .lowSideGate(lowSideGate),
  .overcurrentPulse(overcurrentPulse), .faultActive(faultActive),
  .regulating(regulating));
`default_nettype wire

// *** verification/bsfs_sequencer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsfs_sequencer_tb;
  typedef struct packed {
    logic [1:0]  cls;
    logic [10:0] fb;
    logic [8:0]  trip;
  } bsfs_row_t;
  bsfs_row_t rows [3];
  logic mclk, resetn, uvloActive, cycleStart, startOn, overload, startReqN;
  logic overTripCmp, rampAboveFb, outAboveTarget, oscRun, calSenseEn;
  logic highSideGate, lowSideGate, overcurrentPulse, faultActive, regulating;
  logic [8:0]  cycleTicks, pwmOnTicks, tripLevelMv;
  logic [1:0]  pinCurrentClass;
  logic [10:0] fbMv, extRefMv, intRefMv;
  logic [5:0]  phase_ff;
  int fails, num_checks, cyc, n, k;
  bsfs_sequencer i_dut (.mclk(mclk), .resetn(resetn),
    .uvloActive(uvloActive), .startReqN(startReqN), .cycleStart(cycleStart),
    .cycleTicks(cycleTicks), .pwmOnTicks(pwmOnTicks),
    .pinCurrentClass(pinCurrentClass), .overTripCmp(overTripCmp),
    .rampAboveFb(rampAboveFb), .outAboveTarget(outAboveTarget),
    .extRefMv(extRefMv), .oscRun(oscRun), .calSenseEn(calSenseEn),
    .tripLevelMv(tripLevelMv), .intRefMv(intRefMv),
    .highSideGate(highSideGate), .lowSideGate(lowSideGate),
    .overcurrentPulse(overcurrentPulse), .faultActive(faultActive),
    .regulating(regulating));
  bsfs_far_side i_far (.startOn(startOn), .overload(overload), .fbMv(fbMv),
    .intRefMv(intRefMv), .extRefMv(extRefMv), .highSideGate(highSideGate),
    .startReqN(startReqN), .overTripCmp(overTripCmp),
    .rampAboveFb(rampAboveFb), .outAboveTarget(outAboveTarget));
  // ==========================
  // clock, oscillator, watchdog
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    // 44-tick cycle keeps three calibrations under the cycle budget
    phase_ff <= (phase_ff == 6'h2B) ? 6'h00 : phase_ff + 6'h01;
    cycleStart <= (phase_ff == 6'h2B);
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      fails++;
      test_done();
    end
  end
  // ==========================
  // tasks
  task automatic tick;
    @(negedge mclk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // w selects sensing, regulating or fault
  task automatic count_while(input int w, input logic v);
    n = 0;
    while ((w == 0 ? calSenseEn : w == 1 ? regulating : faultActive) === v
           && n < 40000) begin
      tick;
      n++;
      k += overcurrentPulse;
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================
  // main sequence
  initial begin
    mclk = 0; resetn = 0; uvloActive = 0; startOn = 0; overload = 0;
    phase_ff = 0; cycleStart = 0; cyc = 0; fails = 0; num_checks = 0;
    fbMv = 0; pinCurrentClass = 0; extRefMv = 11'h00A;
    cycleTicks = 9'h02C; pwmOnTicks = 9'h02A;
    rows[0] = {2'h0, 11'h000, 9'h0B4};
    rows[1] = {2'h1, 11'h005, 9'h069};
    rows[2] = {2'h2, 11'h000, 9'h136};
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    tick;
    check(tripLevelMv, 9'h0B4);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      startOn <= 1'b0;
      repeat (150) tick;
      check({calSenseEn, highSideGate, lowSideGate, regulating}, 0);
      @(posedge mclk);
      pinCurrentClass <= rows[i].cls;
      fbMv <= rows[i].fb;
      startOn <= 1'b1;
      count_while(0, 1'b0);
      count_while(0, 1'b1);
      check((n + 22) / 44, 600);
      count_while(1, 1'b0);
      check(n >= 23 * 44 && n <= 26 * 44, 1);
      check(tripLevelMv, rows[i].trip);
    end
    // output held above target: rectifier must conduct in run
    @(posedge mclk);
    fbMv <= 11'h014;
    n = 0;
    repeat (88) begin
      tick;
      n += lowSideGate;
    end
    check(n > 0, 1);
    check(oscRun, 1'b1);
    // short burst, then drain: a floored counter needs seven fresh pulses
    k = 0;
    @(posedge mclk);
    overload <= 1'b1;
    while (k < 4) begin
      tick;
      k += overcurrentPulse;
    end
    @(posedge mclk);
    overload <= 1'b0;
    repeat (480) tick;
    @(posedge mclk);
    overload <= 1'b1;
    count_while(2, 1'b0);
    check(k, 11);
    repeat (240) tick;
    check({highSideGate, lowSideGate, faultActive}, 3'h1);
    @(posedge mclk);
    uvloActive <= 1'b1;
    repeat (3) tick;
    check({oscRun, highSideGate, lowSideGate, faultActive}, 0);
    @(posedge mclk);
    uvloActive <= 1'b0;
    overload <= 1'b0;
    repeat (200) tick;
    @(posedge mclk);
    resetn <= 1'b0;
    tick;
    check({calSenseEn, tripLevelMv}, {1'b0, 9'h0B4});
    test_done();
  end
endmodule
`default_nettype wire
